/* File: logic/laser_ctrl_regs.svh */
`ifndef LASER_CTRL_REGS_SVH
`define LASER_CTRL_REGS_SVH

// Clock period in ns
`define SYS_CLK_NS       20
// Output-enable delay after power-on, ms
`define INIT_MS          20
`define INIT_CYC         ((`INIT_MS * 1000000) / `SYS_CLK_NS)
// Comparator slot time in ns (1.6 us)
`define SLOT_NS          1600
`define SLOT_CYC         (`SLOT_NS / `SYS_CLK_NS)
// Disable deadline in ns
`define OFF_NS           5000
`define OFF_CYC          (`OFF_NS / `SYS_CLK_NS)
// Nonvolatile write time, ms
`define NVW_MS           20
`define NVW_CYC          ((`NVW_MS * 1000000) / `SYS_CLK_NS)
// Slots per sequence and slot numbers of the checks
`define SLOTS            8
`define SLOT_POWER       3'h5
`define SLOT_BIAS        3'h6
`define SLOT_LOSS        3'h7
// Search length limit in bias samples
`define SEARCH_MAX       10
// Steps before overshoot expected
`define STEP_LIMIT       4
// Bias and modulation code widths and top bit
`define DAC_W            10
`define DAC_TOP          9
`endif

/* File: logic/laser_ctrl_pkg.sv */
package laser_ctrl_pkg;
    // Start-up sequence of the bias path
    typedef enum logic [2:0] {
        ST_WAIT_INIT,
        ST_STEP,
        ST_SEARCH,
        ST_TRACK,
        ST_OFF
    } bias_state_t;
    // What the shared comparator looks at in a slot
    typedef enum logic [1:0] {
        CMP_APC,
        CMP_POWER,
        CMP_BIAS,
        CMP_LOSS
    } cmp_sel_t;
endpackage

/* File: logic/pin_sync.sv */
// Three-flop input synchroniser; output changes when stages 2 and 3 agree
module pin_sync (
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic clkEn,
    input  wire logic pinIn,
    output logic      pinOut
);
    logic [2:0] stage_r;  // Shift chain
    logic [2:0] stage_nxt;
    logic       out_r;    // Filtered level
    logic       out_nxt;

    // Next values of the chain and filtered level
    always_comb begin
        stage_nxt = {stage_r[1:0], pinIn};
        out_nxt   = out_r;
        if (stage_r[2] == stage_r[1]) begin
            out_nxt = stage_r[2];
        end
    end

    // Register the chain, frozen when the enable is low
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            stage_r <= 3'h0;
            out_r   <= 1'h0;
        end else if (clkEn) begin
            stage_r <= stage_nxt;
            out_r   <= out_nxt;
        end
    end

    assign pinOut = out_r;
endmodule

/* File: logic/laser_ctrl_quick_trip.sv */
`include "laser_ctrl_regs.svh"
// Bias start-up search, shared quick-trip comparator and output gating
module laser_ctrl_quick_trip #(
    parameter int INIT_CYCLES = `INIT_CYC,  // Power-on enable delay
    parameter int NVW_CYCLES  = `NVW_CYC    // Nonvolatile write time
) (
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    input  wire logic              clkEn,
    input  wire logic              tempDone,         // Temperature conversion done
    input  wire logic              modFetched,       // Modulation value fetched
    input  wire logic              supplyOk,         // Supply above low alarm
    input  wire logic [`DAC_TOP:0] modTableValue,    // Modulation table value
    input  wire logic [`DAC_TOP:0] initialBiasStep,  // Programmed first step
    input  wire logic              txDisablePin,     // Transmit disable pin
    input  wire logic              powerFeedbackHigh,// Feedback above set point
    input  wire logic              powerAboveHigh,   // Feedback above high limit
    input  wire logic              powerBelowLow,    // Feedback below low limit
    input  wire logic              monOneAboveBias,  // First monitor above bias limit
    input  wire logic              diffBelowLow,     // Diff monitor below low level
    input  wire logic              diffAboveHigh,    // Diff monitor above high level
    input  wire logic              txFaultPinIn,     // Fault pin level seen
    input  wire logic              busStop,          // Serial stop seen
    input  wire logic              writePending,     // Write data buffered
    output logic [`DAC_TOP:0]      biasOutput,       // Bias code
    output logic [`DAC_TOP:0]      modulationOutput, // Modulation code
    output logic                   txOffOutput,      // Transmit off output
    output logic                   rxLossOutput,     // Receive loss output
    output logic                   txFaultPinOut,    // Fault pin drive value
    output logic                   txFaultPinOe,     // Fault pin drives low
    output logic                   nvWriteBusy,      // Nonvolatile write running
    output logic                   alarmsUnmasked,   // Search done
    output logic [1:0]             cmpSelect         // Comparator input select
);
    // Synchronised pins
    logic txdSync;  // Disable pin level
    logic txfSync;  // External fault level

    // Transmit disable from outside
    pin_sync uTxd (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .clkEn   (clkEn),
        .pinIn   (txDisablePin),
        .pinOut  (txdSync)
    );
    // Fault pin read back
    pin_sync uTxf (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .clkEn   (clkEn),
        .pinIn   (txFaultPinIn),
        .pinOut  (txfSync)
    );

    // Slot timing state
    logic [6:0]  slotCnt_r, slotCnt_nxt;   // Cycles inside a slot
    logic [2:0]  slotIdx_r, slotIdx_nxt;   // Slot within the sequence of 8
    logic        slotEnd;                  // Last cycle of a slot

    // Bias path state
    laser_ctrl_pkg::bias_state_t state_r, state_nxt;
    logic [23:0] initCnt_r, initCnt_nxt;   // Power-on delay counter
    logic [`DAC_TOP:0] bias_r, bias_nxt;    // Bias code
    logic [`DAC_TOP:0] mod_r, mod_nxt;      // Modulation code
    logic [`DAC_TOP:0] step_r, step_nxt;    // Present search step
    logic [3:0]  samples_r, samples_nxt;   // Bias samples in search
    logic        initDone_r, initDone_nxt; // Power-on delay elapsed and preconditions met
    logic        txOff_r, txOff_nxt;       // Transmit off level
    logic        unmask_r, unmask_nxt;     // Alarms live
    logic        txdSeen_r, txdSeen_nxt;   // Disable seen high while off

    // Quick-trip results
    logic        loss_r, loss_nxt;         // Receive loss level
    logic        pwrFault_r, pwrFault_nxt; // Power trip
    logic        biasFault_r, biasFault_nxt; // High bias trip
    logic        lastHigh_r, lastHigh_nxt; // Last loop compare was high
    logic [1:0]  sel_r, sel_nxt;           // Comparator select
    logic        oe_r, oe_nxt;             // Fault pin pull-down enable

    // Nonvolatile write timer
    logic [23:0] nvCnt_r, nvCnt_nxt;
    logic        nvBusy_r, nvBusy_nxt;
    logic        fault;                    // Any fault

    // Map a slot number to what the comparator looks at
    function automatic logic [1:0] slotKind(input logic [2:0] idx);
        if (idx == `SLOT_POWER) slotKind = 2'(laser_ctrl_pkg::CMP_POWER);
        else if (idx == `SLOT_BIAS) slotKind = 2'(laser_ctrl_pkg::CMP_BIAS);
        else if (idx == `SLOT_LOSS) slotKind = 2'(laser_ctrl_pkg::CMP_LOSS);
        else slotKind = 2'(laser_ctrl_pkg::CMP_APC);
    endfunction

    assign slotEnd = (slotCnt_r == 7'(`SLOT_CYC - 1));
    assign fault   = pwrFault_r | biasFault_r | txfSync;

    // Slot sequencer: 1.6 us slots, eight to a round
    always_comb begin
        slotCnt_nxt = slotEnd ? 7'h00 : slotCnt_r + 7'h01;
        slotIdx_nxt = slotEnd ? slotIdx_r + 3'h1 : slotIdx_r;
        sel_nxt     = slotKind(slotIdx_nxt);
    end

    // Bias start-up, search and tracking
    always_comb begin
        state_nxt    = state_r;
        initCnt_nxt  = initCnt_r;
        initDone_nxt = initDone_r;
        bias_nxt     = bias_r;
        mod_nxt      = mod_r;
        step_nxt     = step_r;
        samples_nxt  = samples_r;
        unmask_nxt   = unmask_r;
        txOff_nxt    = txOff_r;
        txdSeen_nxt  = txdSeen_r;
        unique case (state_r)
            laser_ctrl_pkg::ST_WAIT_INIT: begin
                // Delay then preconditions before enable
                if (initCnt_r != 24'h0) begin
                    initCnt_nxt = initCnt_r - 24'h1;
                end else if (tempDone && modFetched && supplyOk) begin
                    initDone_nxt = 1'b1;
                    mod_nxt      = modTableValue;
                    bias_nxt     = initialBiasStep;
                    state_nxt    = laser_ctrl_pkg::ST_STEP;
                    txOff_nxt    = 1'b0;
                end
            end
            laser_ctrl_pkg::ST_STEP: begin
                // Raise bias by the step until feedback passes set point
                if (slotEnd && sel_r == 2'(laser_ctrl_pkg::CMP_APC)) begin
                    if (powerFeedbackHigh) begin
                        step_nxt    = initialBiasStep >> 1;
                        bias_nxt    = bias_r - (initialBiasStep >> 1);
                        samples_nxt = 4'h1;
                        state_nxt   = laser_ctrl_pkg::ST_SEARCH;
                    end else begin
                        bias_nxt = bias_r + initialBiasStep;
                    end
                end
            end
            laser_ctrl_pkg::ST_SEARCH: begin
                // Halve the step each bias sample; stop at limit
                if (slotEnd && sel_r == 2'(laser_ctrl_pkg::CMP_APC)) begin
                    samples_nxt = samples_r + 4'h1;
                    step_nxt    = step_r >> 1;
                    bias_nxt    = powerFeedbackHigh ? bias_r - (step_r >> 1)
                                                    : bias_r + (step_r >> 1);
                    if (step_r <= `DAC_W'h1 || samples_r == 4'(`SEARCH_MAX - 1)) begin
                        state_nxt  = laser_ctrl_pkg::ST_TRACK;
                        unmask_nxt = 1'b1;
                    end
                end
            end
            laser_ctrl_pkg::ST_TRACK: begin
                // Single-step tracking on loop slots
                if (slotEnd && sel_r == 2'(laser_ctrl_pkg::CMP_APC)) begin
                    bias_nxt = powerFeedbackHigh ? bias_r - `DAC_W'h1
                                                 : bias_r + `DAC_W'h1;
                end
            end
            laser_ctrl_pkg::ST_OFF: begin
                // Disabled; restart only after the disable pin toggles
                if (txdSync) begin
                    txdSeen_nxt = 1'b1;
                end else if (txdSeen_r) begin
                    txdSeen_nxt = 1'b0;
                    mod_nxt   = modTableValue;
                    bias_nxt  = initialBiasStep;
                    txOff_nxt = 1'b0;
                    state_nxt = laser_ctrl_pkg::ST_STEP;
                end
            end
        endcase
        // Disable, or a fault while alarms are live, shuts both outputs next cycle
        if (initDone_r && (txdSync || (fault && unmask_r))) begin
            bias_nxt   = `DAC_W'h0;
            mod_nxt    = `DAC_W'h0;
            txOff_nxt  = 1'b1;
            unmask_nxt = 1'b0;
            state_nxt  = laser_ctrl_pkg::ST_OFF;
        end
    end

    // Quick-trip checks in their own slots
    always_comb begin
        loss_nxt      = loss_r;
        pwrFault_nxt  = pwrFault_r;
        biasFault_nxt = biasFault_r;
        lastHigh_nxt  = lastHigh_r;
        oe_nxt        = txOff_r & ~fault;
        if (slotEnd) begin
            unique case (sel_r)
                2'(laser_ctrl_pkg::CMP_APC): lastHigh_nxt = powerFeedbackHigh;
                2'(laser_ctrl_pkg::CMP_POWER): begin
                    // High or low check chosen by last loop compare
                    pwrFault_nxt = unmask_r &&
                        (lastHigh_r ? powerAboveHigh : powerBelowLow);
                end
                2'(laser_ctrl_pkg::CMP_BIAS):
                    biasFault_nxt = unmask_r && monOneAboveBias;
                2'(laser_ctrl_pkg::CMP_LOSS): begin
                    // Hysteresis: hold between thresholds
                    if (diffBelowLow) begin
                        loss_nxt = 1'b1;
                    end else if (diffAboveHigh) begin
                        loss_nxt = 1'b0;
                    end
                end
            endcase
        end
        // Trips drop once alarms are masked again
        if (!unmask_r) begin
            pwrFault_nxt  = 1'b0;
            biasFault_nxt = 1'b0;
        end
    end

    // Nonvolatile write timing: starts on stop after data
    always_comb begin
        nvCnt_nxt  = nvCnt_r;
        nvBusy_nxt = nvBusy_r;
        if (nvBusy_r) begin
            nvCnt_nxt  = nvCnt_r - 24'h1;
            nvBusy_nxt = (nvCnt_r != 24'h1);
        end else if (busStop && writePending) begin
            nvCnt_nxt  = 24'(NVW_CYCLES);
            nvBusy_nxt = 1'b1;
        end
    end

    // Register all state
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            slotCnt_r   <= 7'h00;
            slotIdx_r   <= 3'h0;
            sel_r       <= 2'h0;
            state_r     <= laser_ctrl_pkg::ST_WAIT_INIT;
            initCnt_r   <= 24'(INIT_CYCLES);
            initDone_r  <= 1'b0;
            bias_r      <= `DAC_W'h0;
            mod_r       <= `DAC_W'h0;
            step_r      <= `DAC_W'h0;
            samples_r   <= 4'h0;
            unmask_r    <= 1'b0;
            txOff_r     <= 1'b1;
            txdSeen_r   <= 1'b0;
            oe_r        <= 1'b0;
            loss_r      <= 1'b0;
            pwrFault_r  <= 1'b0;
            biasFault_r <= 1'b0;
            lastHigh_r  <= 1'b0;
            nvCnt_r     <= 24'h0;
            nvBusy_r    <= 1'b0;
        end else if (clkEn) begin
            slotCnt_r   <= slotCnt_nxt;
            slotIdx_r   <= slotIdx_nxt;
            sel_r       <= sel_nxt;
            state_r     <= state_nxt;
            initCnt_r   <= initCnt_nxt;
            initDone_r  <= initDone_nxt;
            bias_r      <= bias_nxt;
            mod_r       <= mod_nxt;
            step_r      <= step_nxt;
            samples_r   <= samples_nxt;
            unmask_r    <= unmask_nxt;
            txOff_r     <= txOff_nxt;
            txdSeen_r   <= txdSeen_nxt;
            oe_r        <= oe_nxt;
            loss_r      <= loss_nxt;
            pwrFault_r  <= pwrFault_nxt;
            biasFault_r <= biasFault_nxt;
            lastHigh_r  <= lastHigh_nxt;
            nvCnt_r     <= nvCnt_nxt;
            nvBusy_r    <= nvBusy_nxt;
        end
    end

    // Outputs straight from flops, fault pin drive value tied low; fault pin pulls low while idle-fault free
    assign biasOutput       = bias_r;
    assign modulationOutput = mod_r;
    assign txOffOutput      = txOff_r;
    assign rxLossOutput     = loss_r;
    assign txFaultPinOut    = 1'b0;
    assign txFaultPinOe     = oe_r;
    assign nvWriteBusy      = nvBusy_r;
    assign alarmsUnmasked   = unmask_r;
    assign cmpSelect        = sel_r;

    // Loss output rises after a low sample in the loss slot
    AST_LOSS_RISE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clkEn && slotEnd && sel_r == 2'(laser_ctrl_pkg::CMP_LOSS) && diffBelowLow
        |=> rxLossOutput) else $error("loss output not raised");
    // Loss output falls after a high sample
    AST_LOSS_FALL: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clkEn && slotEnd && sel_r == 2'(laser_ctrl_pkg::CMP_LOSS) && !diffBelowLow
        && diffAboveHigh |=> !rxLossOutput) else $error("loss output not cleared");
    // Loss output only changes at loss slot ends
    AST_LOSS_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !(slotEnd && sel_r == 2'(laser_ctrl_pkg::CMP_LOSS)) |=> $stable(rxLossOutput))
        else $error("loss output moved outside its slot");
    // Disable pin turns outputs off well inside the deadline
    AST_TXD_OFF: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clkEn && txdSync && initDone_r |=> bias_r == `DAC_W'h0 && mod_r == `DAC_W'h0)
        else $error("outputs not disabled");
    // Slot index steps once per slot
    AST_SLOT_STEP: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clkEn && slotEnd |=> slotIdx_r == $past(slotIdx_r) + 3'h1)
        else $error("slot index did not advance");
    // Loop slots are five of eight
    AST_SLOT_MAP: assert property (@(posedge sys_clk) disable iff (!rst_n)
        slotIdx_r < `SLOT_POWER |-> sel_r == 2'(laser_ctrl_pkg::CMP_APC))
        else $error("loop slot mapped wrongly");
    // Alarms stay masked before tracking
    AST_MASK: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state_r == laser_ctrl_pkg::ST_STEP || state_r == laser_ctrl_pkg::ST_SEARCH
        |-> !unmask_r) else $error("alarms live during search");
    // Search never exceeds ten samples
    AST_SEARCH_LEN: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state_r == laser_ctrl_pkg::ST_SEARCH |-> samples_r <= 4'(`SEARCH_MAX))
        else $error("search too long");
    // Outputs off until the power-on preconditions have held
    AST_INIT: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !initDone_r |-> txOff_r && bias_r == `DAC_W'h0) else $error("early enable");
    // Write starts only on stop
    AST_NVW: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(nvBusy_r) |-> $past(busStop)) else $error("write without stop");
endmodule

/* File: verif/front_end_model.sv */
// Analog front end behind the comparator: laser feedback and receive monitor
module front_end_model #(
    parameter int SET_POINT = 500,  // Bias code where feedback crosses set point
    parameter int LOW_T     = 40,   // Low loss threshold
    parameter int HIGH_T    = 80    // High loss threshold
) (
    input  wire logic [9:0] biasOutput,        // Bias code from the block
    input  wire logic [7:0] diffLevel,         // Differential monitor level
    output logic            powerFeedbackHigh, // Feedback above set point
    output logic            diffBelowLow,      // Below low threshold
    output logic            diffAboveHigh      // Above high threshold
);
    timeunit 1ns;
    timeprecision 1ps;
    // Feedback follows bias through the laser
    assign powerFeedbackHigh = (int'(biasOutput) >= SET_POINT);
    // One differential level feeds both loss comparisons
    assign diffBelowLow  = (int'(diffLevel) < LOW_T);
    assign diffAboveHigh = (int'(diffLevel) > HIGH_T);
endmodule

/* File: verif/tb_top.sv */
// Self-checking bench for the quick-trip block
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SP = 500;  // Set point code of the model
    localparam int NVW = 20;  // Shortened write time
    logic       sys_clk = 1'b0;  // System clock
    logic       rst_n = 1'b0;    // Reset, active low
    logic       clkEn = 1'b1;    // Clock enable
    logic       tempDone = 1'b0, modFetched = 1'b0, supplyOk = 1'b0;
    logic [9:0] modTableValue = 10'h000, initialBiasStep = 10'h000;
    logic       txDisablePin = 1'b0, powerAboveHigh = 1'b0;
    logic       txFaultPinIn = 1'b0, busStop = 1'b0, writePending = 1'b0;
    logic [7:0] diffLevel = 8'h60;  // Start above high threshold
    logic       powerFeedbackHigh, diffBelowLow, diffAboveHigh;
    logic [9:0] biasOutput, modulationOutput;
    logic       txOffOutput, rxLossOutput, txFaultPinOut, txFaultPinOe;
    logic       nvWriteBusy, alarmsUnmasked;
    logic [1:0] cmpSelect;
    int         err_total = 0;  // Mismatch count
    int         compares = 0;   // Comparison count
    int         seed = 32'h1b22;
    int         slotExp[8] = '{0, 0, 0, 0, 0, 1, 2, 3};  // Slot order model
    int         n;
    always #10 sys_clk = ~sys_clk;
    laser_ctrl_quick_trip #(.INIT_CYCLES(20), .NVW_CYCLES(NVW)) i_laser_ctrl_quick_trip (
        .sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn), .tempDone(tempDone),
        .modFetched(modFetched), .supplyOk(supplyOk), .modTableValue(modTableValue),
        .initialBiasStep(initialBiasStep), .txDisablePin(txDisablePin),
        .powerFeedbackHigh(powerFeedbackHigh), .powerAboveHigh(powerAboveHigh),
        .powerBelowLow(1'b0), .monOneAboveBias(1'b0), .diffBelowLow(diffBelowLow),
        .diffAboveHigh(diffAboveHigh), .txFaultPinIn(txFaultPinIn), .busStop(busStop),
        .writePending(writePending), .biasOutput(biasOutput),
        .modulationOutput(modulationOutput), .txOffOutput(txOffOutput),
        .rxLossOutput(rxLossOutput), .txFaultPinOut(txFaultPinOut),
        .txFaultPinOe(txFaultPinOe), .nvWriteBusy(nvWriteBusy),
        .alarmsUnmasked(alarmsUnmasked), .cmpSelect(cmpSelect));
    front_end_model #(.SET_POINT(SP)) i_front_end_model (
        .biasOutput(biasOutput), .diffLevel(diffLevel),
        .powerFeedbackHigh(powerFeedbackHigh), .diffBelowLow(diffBelowLow),
        .diffAboveHigh(diffAboveHigh));
    // Prints counts and verdict, then ends the run
    task automatic report_and_stop();
        $display("Compares %0d, mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Compares a code value
    task automatic chk10(input logic [9:0] got, input logic [9:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("Error %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    // Compares a single flag
    task automatic chk1(input logic got, input logic exp, input string m);
        chk10({9'h000, got}, {9'h000, exp}, m);
    endtask
    // Waits at falling edges until the selected flag reaches a level
    task automatic wait_flag(input int sel, input logic val, input int lim);
        logic f;
        for (n = 0; n < lim; n++) begin
            @(negedge sys_clk);
            case (sel)
                0: f = txOffOutput;
                1: f = rxLossOutput;
                2: f = alarmsUnmasked;
                default: f = (cmpSelect === 2'h3);
            endcase
            if (f === val) begin
                return;
            end
        end
    endtask
    // Waits for outputs to come up and checks the start-up search
    task automatic start_up();
        wait_flag(0, 1'b0, 4000);
        chk1(txOffOutput, 1'b0, "outputs on");
        chk10(modulationOutput, modTableValue, "mod load");
        chk1(alarmsUnmasked, 1'b0, "masked in search");
        wait_flag(2, 1'b1, 4000);
        chk1(alarmsUnmasked, 1'b1, "search done");
        n = int'(biasOutput) - SP;
        chk1(n * n * 10000 <= 9 * SP * SP, 1'b1, "bias within 3%");
    endtask
    // Watchdog cuts a hang short
    initial begin
        repeat (60000) @(posedge sys_clk);
        err_total++;
        report_and_stop();
    end
    // Main sequence
    initial begin
        repeat (2) @(negedge sys_clk);
        rst_n <= 1'b1;
        @(negedge sys_clk);
        chk10(biasOutput, 10'h000, "bias reset");
        chk1(txOffOutput, 1'b1, "off at reset");
        chk1(rxLossOutput, 1'b0, "loss reset");
        // Slot order and length: 80 cycles per slot, eight slots
        wait_flag(3, 1'b1, 700);
        repeat (40) @(negedge sys_clk);
        for (int k = 0; k < 8; k++) begin
            repeat (80) @(negedge sys_clk);
            chk10({8'h00, cmpSelect}, 10'(slotExp[k]), "slot select");
        end
        // Enable low freezes the slot timer inside the loss slot
        clkEn = 1'b0;
        repeat (100) @(negedge sys_clk);
        clkEn = 1'b1;
        repeat (30) @(negedge sys_clk);
        chk10({8'h00, cmpSelect}, 10'h003, "frozen slot");
        // Enable held back while supply is low
        modTableValue = 10'($unsigned($random(seed)) % 1024);
        initialBiasStep = 10'(130 + $unsigned($random(seed)) % 64);
        tempDone = 1'b1;
        modFetched = 1'b1;
        repeat (100) @(negedge sys_clk);
        chk1(txOffOutput, 1'b1, "off until supply ok");
        supplyOk = 1'b1;
        start_up();
        // Loss hysteresis through the differential monitor
        diffLevel = 8'h10;
        wait_flag(1, 1'b1, 660);
        chk1(rxLossOutput, 1'b1, "loss set below low");
        diffLevel = 8'h3c;
        repeat (1300) @(negedge sys_clk);
        chk1(rxLossOutput, 1'b1, "loss held");
        diffLevel = 8'h90;
        wait_flag(1, 1'b0, 660);
        chk1(rxLossOutput, 1'b0, "loss clear above high");
        diffLevel = 8'h48;
        repeat (1300) @(negedge sys_clk);
        chk1(rxLossOutput, 1'b0, "loss held low");
        // Disable turns both outputs off inside the deadline
        txDisablePin = 1'b1;
        repeat (250) @(negedge sys_clk);
        chk10(biasOutput, 10'h000, "bias off");
        chk10(modulationOutput, 10'h000, "mod off");
        chk1(txOffOutput, 1'b1, "tx off");
        txDisablePin = 1'b0;
        start_up();
        // Power trip after unmasking shuts outputs
        powerAboveHigh = 1'b1;
        wait_flag(0, 1'b1, 1400);
        chk1(txOffOutput, 1'b1, "power trip");
        powerAboveHigh = 1'b0;
        // External fault on the fault pin
        txDisablePin = 1'b1;
        repeat (20) @(negedge sys_clk);
        chk1(txFaultPinOe, 1'b1, "pin low no fault");
        txFaultPinIn = 1'b1;
        repeat (20) @(negedge sys_clk);
        chk1(txFaultPinOe, 1'b0, "pin released");
        chk1(txFaultPinOut, 1'b0, "open drain");
        txFaultPinIn = 1'b0;
        txDisablePin = 1'b0;
        start_up();
        // Stop without write data starts nothing
        busStop = 1'b1;
        @(negedge sys_clk);
        busStop = 1'b0;
        repeat (3) @(negedge sys_clk);
        chk1(nvWriteBusy, 1'b0, "no write");
        // Stop after write data starts the timed write
        writePending = 1'b1;
        busStop = 1'b1;
        @(negedge sys_clk);
        busStop = 1'b0;
        writePending = 1'b0;
        chk1(nvWriteBusy, 1'b1, "write starts");
        n = 1;
        for (int k = 0; k < 40; k++) begin
            @(negedge sys_clk);
            n += (nvWriteBusy === 1'b1) ? 1 : 0;
        end
        chk10(10'(n), 10'(NVW), "write length");
        report_and_stop();
    end
endmodule
